/* rtl/hp_host_port.sv */
// Host port: lets an external host read and write internal memory,
// 8-bit multiplexed or 16-bit direct. Memory side is a simple request port.
// Notes on behaviour
// R01: Wide mode uses direct address and data
// R02: Wide data bus floats unless driving reads
// R03: Wide bus keepers, off at reset, control bit
// R04: Narrow bus keepers, off at reset, control bit
// R05: Narrow bus bidirectional; general I/O in wide
// R06: Select inputs pick one of three registers
// R07: Byte id orders bytes; ignored in wide
// R08: Host keeps chip select low whole access
// R09: Host drives strobes that time transfers
// R10: Address strobe latches address into register
// R11: Read/write sets direction; drive only reads
// R12: Ready output shows port can take transfer
// R13: Host irq high in reset; invalid wide
// R14: Port disabled: timer pulse on irq pin
// R15: Enable pin sampled at reset release
// R16: Disabled port ignores enable until reset
// R17: Wide mode lacks control and address registers
// R18: No interrupts either way in wide mode
// R19: Pull-ups only while enable pin low
// R20: Output-disable low floats ready, irq, data
// R21: Host waits for ready before next strobe
module hp_host_port
  import hp_pkg::*;
(
  input  wire logic        clk,              // 50 MHz clock
  input  wire logic        rstn,             // Synchronous reset, low active
  input  wire logic        port_enable_pin,  // Strap sampled at reset release
  input  wire logic        wide_mode_select, // High selects 16-bit mode
  input  wire logic        out_disable_n,    // Low floats all outputs
  input  wire logic        hold_req,         // Bus hold request
  input  wire logic        main_keeper_enable,// Wide bus keeper control bit
  input  wire logic        port_keeper_enable,// Narrow bus keeper control bit
  input  wire logic        timer_b_pulse_out,// Second timer underflow pulse
  input  wire logic        dsp_irq_req,      // Processor raises host irq
  input  wire logic        reg_select_0,     // Register select bit 0
  input  wire logic        reg_select_1,     // Register select bit 1
  input  wire logic        byte_order_id,    // High: second byte
  input  wire logic        port_chip_select_n,// Chip select, low active
  input  wire logic        data_strobe_a_n,  // Data strobe a
  input  wire logic        data_strobe_b_n,  // Data strobe b
  input  wire logic        addr_strobe_n,    // Address strobe, low active
  input  wire logic        read_not_write,   // High: read
  input  wire logic [15:0] wide_address_in,  // Direct address, wide mode
  input  wire logic [15:0] wide_data_in,     // Wide bus pin level
  output logic      [15:0] wide_data_out,    // Wide bus drive value
  output logic             wide_data_oe,     // Wide bus drive enable
  output logic             wide_keeper_on,   // Wide bus keepers active
  input  wire logic [7:0]  narrow_data_in,   // Narrow bus pin level
  output logic      [7:0]  narrow_data_out,  // Narrow bus drive value
  output logic             narrow_data_oe,   // Narrow bus drive enable
  output logic             narrow_keeper_on, // Narrow bus keepers active
  output logic      [7:0]  gpio_in,          // Narrow pins as inputs, wide mode
  input  wire logic [7:0]  gpio_out,         // General output value
  input  wire logic        gpio_oe,          // General output enable
  output logic             port_ready_out,   // Ready level
  output logic             port_ready_oe,    // Ready drive enable
  output logic             host_irq_out,     // Irq/timer pin value
  output logic             host_irq_oe,      // Irq/timer pin drive enable
  output logic             pullup_ctrl_on,   // Pull-ups on strobe, rw, cs
  output logic             pullup_sel_on,    // Pull-ups on select inputs
  output logic             port_active,      // Port enabled by strap
  output logic      [15:0] mem_addr,         // Memory address
  output logic      [15:0] mem_wdata,        // Memory write data
  output logic             mem_req,          // Memory request valid
  output logic             mem_we,           // Memory write
  input  wire logic        mem_ack,          // Memory accepted request
  input  wire logic        mem_rvalid,       // Read data valid
  input  wire logic [15:0] mem_rdata,        // Read data
  output logic      [15:0] host_ctrl_value   // Control register contents
);
  hp_state_t   state_reg, state_next;
  logic [15:0] addr_reg, ctrl_reg, rdata_reg, wbuf_reg;
  logic        en_reg, strap_done_reg, irq_reg, rd_pend_reg;
  logic        strobe, start_p, end_p, as_reg;
  logic [1:0]  sel;
  logic        wide, narrow_hi, sel_data, is_read, take_write, word_done;
  logic        drive_read;
  logic [31:0] fin_data, fout_data;
  logic        fin_valid, fin_ready, fout_valid, fout_ready;

  hp_strobe u_strobe (
    .clk     (clk),
    .rstn    (rstn),
    .cs_n    (port_chip_select_n),
    .ds_a_n  (data_strobe_a_n),
    .ds_b_n  (data_strobe_b_n),
    .strobe  (strobe),
    .start_p (start_p),
    .end_p   (end_p)
  );

  // Access decode [R06] [R07] [R09] [R11]
  assign wide      = wide_mode_select && en_reg;                  // [R01] [R17]
  assign sel       = {reg_select_1, reg_select_0};                // [R06]
  assign narrow_hi = !wide && byte_order_id;                      // [R07]
  assign sel_data  = wide || sel == SEL_DATA || sel == SEL_DATA_I;
  assign is_read   = read_not_write;                              // [R11]
  // A narrow write completes a word on the second byte; wide always whole
  assign word_done = wide || byte_order_id;
  assign take_write = end_p && en_reg && sel_data && !is_read && word_done;

  // Strap capture at reset release; held until next reset [R15] [R16]
  always_ff @(posedge clk) begin
    if (!rstn) begin
      en_reg         <= 1'b0;
      strap_done_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      en_reg         <= port_enable_pin;                          // [R15]
      strap_done_reg <= 1'b1;                                     // [R16]
    end
  end

  // Write words queue to memory with their address; the last byte is merged
  // here because the buffer register only catches it at the same edge
  assign fin_data  = {(wide ? wide_address_in : addr_reg),
                      (wide ? wide_data_in : hp_merge(wbuf_reg, narrow_data_in, byte_order_id))};
  assign fin_valid = take_write;
  hp_fifo #(.WIDTH(FIFO_WIDTH + ADDR_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .in_data   (fin_data),
    .in_valid  (fin_valid),
    .in_ready  (fin_ready),
    .out_data  (fout_data),
    .out_valid (fout_valid),
    .out_ready (fout_ready)
  );
  assign fout_ready = (state_reg == HP_IDLE) && mem_ack;

  // Memory request selection: queued writes first, then pending read
  assign mem_req   = (state_reg == HP_IDLE) && (fout_valid || rd_pend_reg);
  assign mem_we    = fout_valid;
  assign mem_wdata = fout_data[15:0];
  assign mem_addr  = fout_valid ? fout_data[31:16]
                   : (wide ? wide_address_in : addr_reg);        // [R01]

  // Read sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      HP_IDLE: if (!fout_valid && rd_pend_reg && mem_ack) state_next = HP_BUSY;
      HP_BUSY: if (mem_rvalid) state_next = HP_DONE;
      HP_DONE: state_next = HP_IDLE;
      default: state_next = HP_IDLE;
    endcase
  end

  // Registers: address, control, buffers [R10] [R17]
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg   <= HP_IDLE;
      addr_reg    <= ADDR_RST;
      ctrl_reg    <= CTRL_RST;
      rdata_reg   <= '0;
      wbuf_reg    <= '0;
      rd_pend_reg <= 1'b0;
      as_reg      <= 1'b0;
    end else begin
      state_reg <= state_next;
      as_reg    <= !addr_strobe_n;
      // Address strobe edge latches the multiplexed address
      if (en_reg && !wide && !addr_strobe_n && !as_reg && !port_chip_select_n)
        addr_reg <= hp_merge(addr_reg, narrow_data_in, byte_order_id); // [R10]
      else if (end_p && en_reg && !wide && !is_read && sel == SEL_ADDR)
        addr_reg <= hp_merge(addr_reg, narrow_data_in, byte_order_id); // [R06]
      else if (end_p && en_reg && !wide && word_done && sel == SEL_DATA_I)
        addr_reg <= addr_reg + ADDR_STEP;
      if (end_p && en_reg && !wide && !is_read && sel == SEL_CTRL)
        ctrl_reg <= hp_merge(ctrl_reg, narrow_data_in, byte_order_id);
      if (end_p && !is_read)
        wbuf_reg <= wide ? wide_data_in : hp_merge(wbuf_reg, narrow_data_in, byte_order_id);
      // Read fetch starts with the first byte or the wide strobe
      if (start_p && en_reg && sel_data && is_read && (wide || !byte_order_id))
        rd_pend_reg <= 1'b1;
      else if (state_reg == HP_IDLE && !fout_valid && mem_ack)
        rd_pend_reg <= 1'b0;
      if (state_reg == HP_BUSY && mem_rvalid)
        rdata_reg <= mem_rdata;
    end
  end

  // Host irq latch: set wins over a host clear [R13] [R18]
  always_ff @(posedge clk) begin
    if (!rstn)
      irq_reg <= 1'b0;
    else if (dsp_irq_req && !wide)                                // [R18]
      irq_reg <= 1'b1;
    else if (end_p && !is_read && sel == SEL_CTRL && !wide && narrow_data_in[CTRL_IRQ_BIT])
      irq_reg <= 1'b0;
  end

  // Ready: not while a read is in flight or the write queue is full [R12] [R21]
  assign port_ready_out = en_reg && fin_ready && !rd_pend_reg && (state_reg == HP_IDLE);
  assign port_ready_oe  = out_disable_n && en_reg;                // [R20]

  // Irq pin: high in reset, timer pulse when disabled [R13] [R14] [R20]
  assign host_irq_out = !rstn ? 1'b1 : (!en_reg ? timer_b_pulse_out : !irq_reg);
  assign host_irq_oe  = out_disable_n && !(en_reg && wide);

  // Read data driving only during read strobes [R02] [R05] [R11]
  assign drive_read     = strobe && is_read && en_reg && rstn && out_disable_n;
  assign wide_data_oe   = drive_read && wide && !hold_req;       // [R02]
  assign wide_data_out  = rdata_reg;
  assign narrow_data_oe = wide ? (gpio_oe && out_disable_n)      // [R05]
                               : (drive_read && sel_data);
  assign narrow_data_out = wide ? gpio_out
                          : (byte_order_id ? rdata_reg[15:8] : rdata_reg[7:0]);
  assign gpio_in        = narrow_data_in;

  // Keepers, off through reset [R03] [R04]
  assign wide_keeper_on   = rstn && main_keeper_enable;           // [R03]
  assign narrow_keeper_on = rstn && port_keeper_enable;           // [R04]

  // Pull-ups follow the strap pin level [R19]
  assign pullup_ctrl_on  = !port_enable_pin;
  assign pullup_sel_on   = !port_enable_pin && wide_mode_select;
  assign port_active     = en_reg;
  assign host_ctrl_value = wide ? '0 : ctrl_reg;                  // [R17]

  a_strap_hold: assert property (@(posedge clk) disable iff (!rstn)
    strap_done_reg && $past(strap_done_reg) |-> en_reg == $past(en_reg))
    else $error("enable changed after strap"); // [R16]
  a_irq_wide_none: assert property (@(posedge clk) disable iff (!rstn)
    wide |=> !irq_reg || $past(irq_reg)) else $error("irq set in wide mode"); // [R18]
  a_wide_float: assert property (@(posedge clk)
    (hold_req || !rstn || !is_read) |-> !wide_data_oe) else $error("wide bus driven"); // [R02]
  a_off_float: assert property (@(posedge clk)
    !out_disable_n |-> !port_ready_oe && !host_irq_oe && !wide_data_oe)
    else $error("output driven while disabled"); // [R20]
  a_irq_reset_high: assert property (@(posedge clk)
    !rstn |-> host_irq_out) else $error("irq not high in reset"); // [R13]
  a_timer_route: assert property (@(posedge clk) disable iff (!rstn)
    strap_done_reg && !en_reg |-> host_irq_out == timer_b_pulse_out)
    else $error("timer pulse not routed"); // [R14]
  a_keeper_reset: assert property (@(posedge clk)
    !rstn |-> !wide_keeper_on && !narrow_keeper_on) else $error("keeper on in reset"); // [R03]
  a_ready_busy: assert property (@(posedge clk) disable iff (!rstn)
    rd_pend_reg |-> !port_ready_out) else $error("ready during pending read"); // [R12]
  a_read_fetch: assert property (@(posedge clk) disable iff (!rstn)
    state_reg == HP_BUSY && mem_rvalid |=> rdata_reg == $past(mem_rdata))
    else $error("read data not captured"); // [R11]
endmodule : hp_host_port

/* rtl/hp_pkg.sv */
// Shared constants for the host port block.
// Assumes one 50 MHz clock and a synchronous active-low reset.
package hp_pkg;
  localparam int          FIFO_WIDTH = 16;            // Data word width
  localparam int          FIFO_DEPTH = 8;             // Words held in transit
  localparam int          ADDR_W     = 16;            // Internal memory address width
  localparam int          BYTE_W     = 8;             // Narrow bus width
  // Register select encodings on the two select inputs
  localparam logic [1:0]  SEL_CTRL   = 2'h0;          // Host control register
  localparam logic [1:0]  SEL_DATA_I = 2'h1;          // Data with address increment
  localparam logic [1:0]  SEL_ADDR   = 2'h2;          // Host address register
  localparam logic [1:0]  SEL_DATA   = 2'h3;          // Data, fixed address
  localparam logic [15:0] CTRL_RST   = 16'h0000;      // Control register reset value
  localparam logic [15:0] ADDR_RST   = 16'h0000;      // Address register reset value
  localparam logic [0:0]  KEEP_RST   = 1'h0;          // Keepers off during reset
  localparam logic [15:0] ADDR_STEP  = 16'h0001;      // Auto-increment step
  localparam int          CTRL_IRQ_BIT = 1;           // Control bit that clears host irq

  // Access sequencer states, Gray coded along idle-busy-done
  typedef enum logic [1:0] {
    HP_IDLE = 2'b00,
    HP_BUSY = 2'b01,
    HP_DONE = 2'b11
  } hp_state_t;

  // Merge a byte into the high or low half of a word
  function automatic logic [15:0] hp_merge(input logic [15:0] word, input logic [7:0] b,
                                           input logic hi);
    hp_merge = hi ? {b, word[7:0]} : {word[15:8], b};
  endfunction : hp_merge
endpackage : hp_pkg

/* rtl/hp_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; reset is synchronous and active low.
module hp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,      // System clock
  input  wire logic             rstn,     // Synchronous reset, low active
  input  wire logic [WIDTH-1:0] in_data,  // Write data
  input  wire logic             in_valid, // Write request
  output logic                  in_ready, // Not full
  output logic      [WIDTH-1:0] out_data, // Head word
  output logic                  out_valid,// Not empty
  input  wire logic             out_ready // Drain accepts
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg, rd_reg;
  logic [AW:0]      cnt_reg;
  logic             push, pop;

  // Handshake decode
  assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_reg[rd_reg];

  // Pointers and fill count
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      if (pop)  rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Storage needs no reset
  always_ff @(posedge clk) begin
    if (push) mem_reg[wr_reg] <= in_data;
  end

  a_fifo_no_over: assert property (@(posedge clk) disable iff (!rstn)
    cnt_reg <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule : hp_fifo

/* rtl/hp_strobe.sv */
// Strobe combiner: forms the internal strobe from the two data strobes
// and flags its falling and rising edges. Inputs are synchronous.
module hp_strobe (
  input  wire logic clk,        // System clock
  input  wire logic rstn,       // Synchronous reset, low active
  input  wire logic cs_n,       // Chip select, low active
  input  wire logic ds_a_n,     // Data strobe a, low active
  input  wire logic ds_b_n,     // Data strobe b, low active
  output logic      strobe,     // Combined strobe level
  output logic      start_p,    // Strobe just went active
  output logic      end_p       // Strobe just went inactive
);
  logic strobe_reg;

  // Active when chip selected and exactly one strobe low
  assign strobe  = !cs_n && (ds_a_n ^ ds_b_n);
  assign start_p = strobe && !strobe_reg;
  assign end_p   = !strobe && strobe_reg;

  // Previous strobe level
  always_ff @(posedge clk) begin
    if (!rstn) strobe_reg <= 1'b0;
    else       strobe_reg <= strobe;
  end
endmodule : hp_strobe

/* sim/hp_mem_model.sv */
// Behavioural internal memory answering the host port's request port.
// Assumes one clock, synchronous active-low reset, request held until acked.
module hp_mem_model (
  input  wire logic        clk,        // System clock
  input  wire logic        rstn,       // Synchronous reset, low active
  input  wire logic [15:0] mem_addr,   // Request address
  input  wire logic [15:0] mem_wdata,  // Write data
  input  wire logic        mem_req,    // Request valid
  input  wire logic        mem_we,     // Write request
  input  wire logic        mem_stall,  // Bench holds off all acks
  output logic             mem_ack,    // Request taken
  output logic             mem_rvalid, // Read data valid
  output logic      [15:0] mem_rdata   // Read data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [256];
  logic [7:0]  raddr;
  logic        pend;
  wire         take = mem_req && !mem_ack && !mem_stall;
  // Ack one cycle after request, read data one cycle after ack
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mem_ack    <= 1'b0;
      pend       <= 1'b0;
      mem_rvalid <= 1'b0;
    end else begin
      mem_ack    <= take;
      pend       <= take && !mem_we;
      mem_rvalid <= pend;
      if (take) raddr <= mem_addr[7:0];
      if (take && mem_we) mem[mem_addr[7:0]] <= mem_wdata;
    end
    // Stale data toggles so a sample one cycle late never looks right by chance
    mem_rdata <= pend ? mem[raddr] : ~mem_rdata;
  end
endmodule : hp_mem_model

/* sim/hp_host_port_bench.sv */
// Self-checking bench: bench acts as the host, memory model on the far side.
// Assumes the host port contract: strobe-timed transfers, ready before strobe.
module hp_host_port_bench;
  import hp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rstn = 0, port_enable_pin = 1, wide_mode_select = 0, out_disable_n = 1;
  logic hold_req = 0, main_keeper_enable = 1, port_keeper_enable = 1, timer_b_pulse_out = 0;
  logic dsp_irq_req = 0, reg_select_0 = 0, reg_select_1 = 0, byte_order_id = 0;
  logic port_chip_select_n = 1, data_strobe_a_n = 1, data_strobe_b_n = 1, addr_strobe_n = 1;
  logic read_not_write = 1, gpio_oe = 0, mem_stall = 0;
  logic [15:0] wide_address_in = 0, wd_host = 0, wide_data_in, wide_data_out, r;
  logic [7:0]  nd_host = 0, gpio_out = 0, narrow_data_in, narrow_data_out, gpio_in;
  logic wide_data_oe, wide_keeper_on, narrow_data_oe, narrow_keeper_on, port_ready_out;
  logic port_ready_oe, host_irq_out, host_irq_oe, pullup_ctrl_on, pullup_sel_on;
  logic port_active, mem_req, mem_we, mem_ack, mem_rvalid;
  logic [15:0] mem_addr, mem_wdata, mem_rdata, host_ctrl_value;
  int n_errors = 0, total_checks = 0, cycles = 0, n;
  // Pin levels resolved from whoever drives the bus
  assign wide_data_in   = wide_data_oe ? wide_data_out : wd_host;
  assign narrow_data_in = narrow_data_oe ? narrow_data_out : nd_host;
  hp_host_port  i_hp_host_port (.*);
  hp_mem_model  i_hp_mem_model (.*);
  always #10 clk = ~clk;
  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic close_out();
    if (n_errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  task automatic chk1(string nm, logic e, logic s);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %b seen %b", nm, e, s);
    end
  endtask : chk1
  task automatic chk16(string nm, logic [15:0] e, logic [15:0] s);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk16
  task automatic cyc(int k);
    repeat (k) @(negedge clk);
  endtask : cyc
  task automatic wait_rdy();
    int i;
    i = 0;
    while (port_ready_out !== 1'b1 && i < 200) begin
      cyc(1);
      i++;
    end
  endtask : wait_rdy
  // One strobe-timed transfer; data held three cycles past strobe end
  task automatic xfer(logic rd, logic [1:0] sel, logic bid, logic [15:0] wd,
                      output logic [15:0] rv);
    wait_rdy();
    {reg_select_1, reg_select_0} = sel;
    byte_order_id = bid;
    read_not_write = rd;
    wd_host = wd;
    nd_host = wd[7:0];
    port_chip_select_n = 1'b0;
    data_strobe_a_n = 1'b0;
    cyc(2);
    rv = 16'h0000;
    if (rd) begin
      wait_rdy();
      rv = wide_mode_select ? wide_data_out : {8'h00, narrow_data_out};
      chk1("read_oe", 1'b1, wide_mode_select ? wide_data_oe : narrow_data_oe);
    end else chk1("write_oe", 1'b0, narrow_data_oe | wide_data_oe);
    data_strobe_a_n = 1'b1;
    port_chip_select_n = 1'b1;
    // Leave room for a queued write to reach memory
    cyc(3);
    wd_host = ~wd;
    nd_host = ~wd[7:0];
  endtask : xfer
  task automatic nwr(logic [1:0] sel, logic [15:0] w);
    logic [15:0] d;
    xfer(1'b0, sel, 1'b0, {8'h00, w[7:0]}, d);
    xfer(1'b0, sel, 1'b1, {8'h00, w[15:8]}, d);
  endtask : nwr
  task automatic nrd(logic [1:0] sel, output logic [15:0] w);
    logic [15:0] lo, hi;
    xfer(1'b1, sel, 1'b0, 16'h0000, lo);
    xfer(1'b1, sel, 1'b1, 16'h0000, hi);
    w = {hi[7:0], lo[7:0]};
  endtask : nrd
  task automatic astb(logic bid, logic [7:0] b);
    port_chip_select_n = 1'b0;
    byte_order_id = bid;
    nd_host = b;
    addr_strobe_n = 1'b0;
    cyc(2);
    addr_strobe_n = 1'b1;
    port_chip_select_n = 1'b1;
    cyc(1);
  endtask : astb
  task automatic wwr(logic [15:0] a, logic [15:0] w);
    logic [15:0] d;
    wide_address_in = a;
    xfer(1'b0, SEL_DATA, 1'b0, w, d);
  endtask : wwr
  initial begin
    // Reset held with keeper bits set: keepers must still be off
    cyc(4);
    chk1("irq_in_reset", 1'b1, host_irq_out);
    chk1("wide_oe_reset", 1'b0, wide_data_oe);
    chk1("main_keeper_reset", 1'b0, wide_keeper_on);
    chk1("port_keeper_reset", 1'b0, narrow_keeper_on);
    rstn = 1'b1;
    cyc(2);
    chk1("port_active", 1'b1, port_active);
    port_enable_pin = 1'b0;
    cyc(2);
    chk1("strap_ignored", 1'b1, port_active);
    chk1("pullup_low_pin", 1'b1, pullup_ctrl_on);
    port_enable_pin = 1'b1;
    cyc(1);
    chk1("pullup_high_pin", 1'b0, pullup_ctrl_on);
    chk1("main_keeper_on", 1'b1, wide_keeper_on);
    chk1("port_keeper_on", 1'b1, narrow_keeper_on);
    chk1("ready_idle", 1'b1, port_ready_out);
    // Narrow mode: address, data, read back, auto-increment
    nwr(SEL_ADDR, 16'h0010);
    nwr(SEL_DATA, 16'habcd);
    chk16("mem_10", 16'habcd, i_hp_mem_model.mem[16]);
    nrd(SEL_DATA, r);
    chk16("narrow_read", 16'habcd, r);
    nwr(SEL_DATA_I, 16'h1111);
    nwr(SEL_DATA_I, 16'h2222);
    chk16("incr_first", 16'h1111, i_hp_mem_model.mem[16]);
    chk16("incr_second", 16'h2222, i_hp_mem_model.mem[17]);
    astb(1'b0, 8'h20);
    astb(1'b1, 8'h00);
    nwr(SEL_DATA, 16'h7777);
    chk16("addr_strobe", 16'h7777, i_hp_mem_model.mem[32]);
    nwr(SEL_CTRL, 16'h1200);
    chk16("ctrl_value", 16'h1200, host_ctrl_value);
    dsp_irq_req = 1'b1;
    cyc(1);
    dsp_irq_req = 1'b0;
    cyc(2);
    chk1("irq_raised", 1'b0, host_irq_out);
    nwr(SEL_CTRL, 16'h0002);
    chk1("irq_cleared", 1'b1, host_irq_out);
    out_disable_n = 1'b0;
    cyc(1);
    chk1("off_ready", 1'b0, port_ready_oe | host_irq_oe | narrow_data_oe | wide_data_oe);
    out_disable_n = 1'b1;
    // Wide mode: registers gone, narrow pins as general I/O
    wide_mode_select = 1'b1;
    nd_host = 8'h3c;
    cyc(2);
    chk16("wide_ctrl", 16'h0000, host_ctrl_value);
    chk1("pullup_sel_off", 1'b0, pullup_sel_on);
    chk16("gpio_in", 16'h003c, {8'h00, gpio_in});
    gpio_out = 8'hc3;
    gpio_oe = 1'b1;
    cyc(1);
    chk16("gpio_out", 16'h00c3, {8'h00, narrow_data_out});
    chk1("gpio_oe", 1'b1, narrow_data_oe);
    gpio_oe = 1'b0;
    wwr(16'h0040, 16'hbeef);
    chk16("wide_write", 16'hbeef, i_hp_mem_model.mem[64]);
    xfer(1'b1, SEL_DATA, 1'b1, 16'h0000, r);
    chk16("wide_read", 16'hbeef, r);
    // Read on the second strobe, then a hold request floats the bus
    read_not_write = 1'b1;
    port_chip_select_n = 1'b0;
    data_strobe_b_n = 1'b0;
    cyc(2);
    wait_rdy();
    chk1("strobe_b_read", 1'b1, wide_data_oe);
    hold_req = 1'b1;
    cyc(1);
    chk1("hold_float", 1'b0, wide_data_oe);
    hold_req = 1'b0;
    data_strobe_b_n = 1'b1;
    port_chip_select_n = 1'b1;
    cyc(2);
    // Stalled memory: fill buffer until ready drops, then drain
    mem_stall = 1'b1;
    n = 0;
    while (port_ready_out === 1'b1 && n < 12) begin
      wwr(16'h0080 + 16'(n), 16'h0100 + 16'(n));
      n++;
    end
    chk16("fifo_fill", 16'(FIFO_DEPTH), 16'(n));
    mem_stall = 1'b0;
    cyc(40);
    chk16("drain_first", 16'h0100, i_hp_mem_model.mem[128]);
    chk16("drain_last", 16'h0107, i_hp_mem_model.mem[135]);
    chk1("ready_drained", 1'b1, port_ready_out);
    // Strap low at reset: port off, timer pulse on irq pin
    wide_mode_select = 1'b0;
    rstn = 1'b0;
    port_enable_pin = 1'b0;
    cyc(4);
    rstn = 1'b1;
    cyc(2);
    chk1("port_off", 1'b0, port_active);
    port_enable_pin = 1'b1;
    cyc(2);
    chk1("stays_off", 1'b0, port_active);
    timer_b_pulse_out = 1'b1;
    cyc(1);
    chk1("timer_high", 1'b1, host_irq_out & host_irq_oe);
    timer_b_pulse_out = 1'b0;
    cyc(1);
    chk1("timer_low", 1'b0, host_irq_out);
    close_out();
  end
endmodule : hp_host_port_bench
